// ### bench/key_reset_and_diag_monitor_bench.sv
/*
  self-checking bench for the key-code and diagnostic monitor.
  assumes the bus waits on hreadyout and a short oscillator divider of 4.
*/
`timescale 1ns/10ps
module key_reset_and_diag_monitor_bench;
  import key_diag_pkg::*;
  logic        hclk, hresetn, reset_pin_n, wdt_timeout, slew_busy;
  logic        osc_halt, osc_clk, fault_o, fault_oe_n;
  ahb_in_t     bi;
  ahb_out_t    bo;
  analog_in_t  ana;
  action_t     act;
  logic [15:0] trim_data;
  logic [7:0]  cref;
  logic [3:0]  trim_addr;
  int          errors, samples_checked, n_rst, n_adc, n_wdt;

  // hready of the single slave is fed back as the bus hready
  key_diag_monitor #(.OSC_DIV(4)) key_diag_monitor_inst (
    .hclk(hclk), .hresetn(hresetn),
    .bus_in({bi[$bits(ahb_in_t)-1:1], bo.hreadyout}), .bus_out(bo),
    .osc_clk(osc_clk), .reset_pin_n(reset_pin_n), .wdt_timeout(wdt_timeout),
    .slew_busy(slew_busy), .analog(ana), .trim_rom_data(trim_data),
    .crc_reference(cref), .trim_rom_addr(trim_addr), .actions(act),
    .fault_o(fault_o), .fault_oe_n(fault_oe_n));

  trim_osc_model trim_osc_model_inst (
    .trim_rom_addr(trim_addr), .trim_rom_data(trim_data),
    .osc_halt(osc_halt), .osc_clk(osc_clk));

  // clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // action pulse counters
  always @(posedge hclk) begin
    n_rst <= n_rst + (act.dev_reset === 1'b1);
    n_adc <= n_adc + (act.adc_start === 1'b1);
    n_wdt <= n_wdt + (act.wdt_restart === 1'b1);
  end

  // expected crc over the model's trim words
  function automatic logic [7:0] crc_ref();
    logic [7:0]  c;
    logic [15:0] w;
    c = CRC_INIT;
    for (int i = 0; i < 16; i++) begin
      w = {4{4'(i)}};
      for (int b = 15; b >= 0; b--) c = (c[7] ^ w[b]) ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc_ref

  task chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // one single transfer; hready is sampled at each rising edge, read data at the last one
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    bi.hsel <= 1'b1;
    bi.haddr <= {24'h000000, a};
    bi.htrans <= 2'h2;
    bi.hwrite <= w;
    bi.hsize <= 3'h2;
    @(posedge hclk);
    while (bo.hreadyout !== 1'b1) @(posedge hclk);
    bi.hsel <= 1'b0;
    bi.htrans <= 2'h0;
    bi.hwdata <= d;
    @(posedge hclk);
    while (bo.hreadyout !== 1'b1) @(posedge hclk);
    r = bo.hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    chk(e, r);
  endtask : rdc

  task t_reset_vals;
    rdc(OFF_DRES, 32'h09);
    rdc(OFF_DCFG, 32'h03);
    rdc(OFF_GSA, 32'h01);
    rdc(OFF_GSB, 32'h00);
    rdc(OFF_NONE, 32'h00);
    wr(OFF_DRES, 32'h01);
    rdc(OFF_DRES, 32'h08);
  endtask : t_reset_vals

  // refresh with bad, good and unchecked crc; blocked writes meanwhile
  task t_refresh;
    cref <= crc_ref() ^ 8'h01;
    wr(OFF_KEY, {16'h0000, KEY_REFRESH});
    wr(OFF_DCFG, 32'h00);
    cyc(20); // hold-off scaled to the refresh length
    rdc(OFF_DRES, 32'h06);
    rdc(OFF_DCFG, 32'h03);
    rdc(OFF_STATUS, 32'h01);
    wr(OFF_DRES, 32'h06);
    rdc(OFF_DRES, 32'h02);
    cref <= crc_ref();
    wr(OFF_KEY, {16'h0000, KEY_REFRESH});
    wr(OFF_NOP, 32'h00);
    wr(OFF_RBSEL, 32'h03);
    cyc(20);
    wr(OFF_DRES, 32'h02);
    rdc(OFF_DRES, 32'h00);
    wr(OFF_DCFG, 32'h02);
    cref <= crc_ref() ^ 8'h80;
    wr(OFF_KEY, {16'h0000, KEY_REFRESH});
    cyc(20);
    rdc(OFF_DRES, 32'h00);
    cref <= crc_ref();
    wr(OFF_DCFG, 32'h03);
  endtask : t_refresh

  task t_keys;
    int r, a, w;
    r = n_rst;
    a = n_adc;
    w = n_wdt;
    wr(OFF_KEY, {16'h0000, KEY_RESET_A});
    wr(OFF_KEY, {16'h0000, KEY_ADC});
    wr(OFF_KEY, {16'h0000, KEY_RESET_B});
    cyc(3);
    chk(r, n_rst);
    chk(a + 1, n_adc);
    wr(OFF_KEY, {16'h0000, KEY_WDT});
    wr(OFF_NOP, 32'h00);
    cyc(3);
    chk(w + 1, n_wdt);
    wr(OFF_DCFG, 32'h07);
    wr(OFF_NOP, 32'h00);
    cyc(3);
    chk(w + 2, n_wdt);
    wr(OFF_KEY, {16'h0000, KEY_RESET_A}); // host sends the pair in order
    wr(OFF_KEY, {16'h0000, KEY_RESET_B});
    cyc(3);
    chk(r + 1, n_rst);
    rdc(OFF_DRES, 32'h09);
    rdc(OFF_DCFG, 32'h03);
    wr(OFF_CONV, 32'h01);
    cyc(20);
    rdc(OFF_DRES, 32'h01);
  endtask : t_keys

  task t_resets;
    wr(OFF_DRES, 32'h01);
    wr(OFF_DCFG, 32'h0B);
    wdt_timeout <= 1'b1;
    cyc(1);
    wdt_timeout <= 1'b0;
    cyc(5);
    rdc(OFF_DRES, 32'h09);
    wr(OFF_DRES, 32'h01);
    rdc(OFF_DRES, 32'h08);
    reset_pin_n <= 1'b0;
    cyc(5);
    reset_pin_n <= 1'b1;
    cyc(10);
    rdc(OFF_DRES, 32'h09);
  endtask : t_resets

  task t_ticks;
    logic [31:0] t0, t1;
    wr(OFF_DCFG, 32'h01);
    bus(1'b0, OFF_TICKS, 32'h00000000, t0);
    cyc(100);
    bus(1'b0, OFF_TICKS, 32'h00000000, t1);
    chk(t0, t1);
    wr(OFF_DCFG, 32'h03);
    bus(1'b0, OFF_TICKS, 32'h00000000, t0);
    cyc(320);
    bus(1'b0, OFF_TICKS, 32'h00000000, t1);
    chk(32'h1, 32'((t1[15:0] - t0[15:0]) inside {[16'd9:16'd11]}));
  endtask : t_ticks

  task t_slew;
    wr(OFF_KEY, {16'h0000, KEY_REFRESH});
    cyc(20);
    wr(OFF_DRES, 32'h3F);
    rdc(OFF_DRES, 32'h00);
    slew_busy <= 1'b1;
    cyc(3);
    rdc(OFF_DRES, 32'h10);
    rdc(OFF_STATUS, 32'h00);
    slew_busy <= 1'b0;
    cyc(3);
    rdc(OFF_DRES, 32'h00);
  endtask : t_slew

  // every trip point, then the supply comparators
  task t_analog;
    for (int k = 0; k < 4; k++) begin
      ana.temp_trip <= 4'(1 << ((k + 1) % 4));
      wr(OFF_GSA, 32'(1 + 2 * k));
      wr(OFF_ARES, 32'h1F);
      rdc(OFF_ARES, 32'h00);
      ana.temp_trip <= 4'(1 << k);
      cyc(3);
      rdc(OFF_ARES, 32'h01);
    end
    chk(32'h0, 32'(fault_oe_n));
    rdc(OFF_STATUS, 32'h02);
    ana.temp_trip <= 4'h0;
    wr(OFF_ARES, 32'h1F);
    rdc(OFF_ARES, 32'h00);
    chk(32'h1, 32'(fault_oe_n));
    ana.supply_bad <= 4'hF;
    cyc(3);
    rdc(OFF_ARES, 32'h00);
    wr(OFF_CONV, 32'h10); // sets the interrupt enable, range stays 0
    wr(OFF_GSB, 32'h01);
    cyc(3);
    rdc(OFF_ARES, 32'h1E);
    ana.supply_bad <= 4'h2;
    wr(OFF_ARES, 32'h1F);
    rdc(OFF_ARES, 32'h04);
    ana.supply_bad <= 4'h0;
    wr(OFF_ARES, 32'h1F);
    rdc(OFF_ARES, 32'h00);
  endtask : t_analog

  task t_osc_stop;
    osc_halt <= 1'b1;
    cyc(150);
    rdc(OFF_DCFG, HALT_SIGNATURE);
    wr(OFF_GSA, 32'h00);
    rdc(OFF_DRES, 32'h20);
    osc_halt <= 1'b0;
    cyc(50);
    wr(OFF_DRES, 32'h20);
    rdc(OFF_DRES, 32'h00);
  endtask : t_osc_stop

  task print_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    {errors, samples_checked, n_rst, n_adc, n_wdt} = '0;
    bi = '0;
    ana = '0;
    cref = 8'h00;
    {hresetn, wdt_timeout, slew_busy, osc_halt} = 4'h0;
    reset_pin_n = 1'b1;
    cyc(20);
    hresetn <= 1'b1;
    cyc(1);
    t_reset_vals();
    t_refresh();
    t_keys();
    t_resets();
    t_ticks();
    t_slew();
    t_analog();
    t_osc_stop();
    print_verdict();
  end

  // watchdog well beyond the thousand or so cycles the tests need
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
endmodule : key_reset_and_diag_monitor_bench

// ### bench/trim_osc_model.sv
/*
  far-side model: trim memory contents and the free-running oscillator.
  assumes the monitor fetches one word per cycle and samples osc_clk itself.
*/
`timescale 1ns/10ps
module trim_osc_model (
  // fetch port
  input  wire logic [3:0]  trim_rom_addr,
  output logic      [15:0] trim_rom_data,
  // oscillator control and output
  input  wire logic        osc_halt,
  output logic             osc_clk
);
  // each word repeats its address nibble, so the crc is easy to predict
  assign trim_rom_data = {4{trim_rom_addr}};

  // oscillator runs free at 80 ns, freezes at its level while halted
  initial begin
    osc_clk = 1'b0;
    forever #40 if (!osc_halt) osc_clk = ~osc_clk;
  end
endmodule : trim_osc_model

// ### hdl/key_diag_monitor.sv
/*
  key-code decoder, reset flagging, calibration refresh with crc check,
  oscillator monitor and sticky diagnostic flags behind an ahb-lite slave.
  assumes a combinational trim memory and analog comparator levels on hclk.
*/
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
// Function
// [R1] key writes trigger refresh, reset, adc, watchdog
// [R2] reset needs 0x15FA then 0xAF51 back-to-back
// [R3] reset from pin, key pair, or watchdog
// [R4] reset sets reset-seen flag, write-1 clears
// [R5] refresh on key or range field change
// [R6] crc mismatch after refresh sets error flag
// [R7] crc check enabled at reset, bit disables
// [R8] writes during refresh flag invalid access; the code does not flag writes to OFF_RBSEL and OFF_NOP
// [R9] host waits 500 us after starting refresh; the bench waits 20 cycles (200 ns)
// [R10] 16-bit counter ticks at oscillator over 10000
// [R11] counter enable bit, set after reset
// [R12] stopped oscillator returns 0x07DEAD signature
// [R13] sticky flags, write-1 reloads current fault
// [R14] trim and slew flags clear themselves
// [R15] live summary bits, digital excludes slew
// [R16] temperature trip selectable, sets flag, fault low
// [R17] supply comparators off at reset, four nodes
// [R18] host enables reference buffer before comparator
// [R19] out-of-window supply sets its node flag
// [R20] watchdog restart by key or any write
// [R21] unknown key cancels pending reset pair
// [R22] counter wraps and holds while disabled
`timescale 1ns/10ps
module key_diag_monitor
  import key_diag_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // register bus
  input  wire ahb_in_t    bus_in,
  output ahb_out_t        bus_out,
  // pins from outside the clock domain
  input  wire logic       osc_clk,
  input  wire logic       reset_pin_n,
  // device-side inputs
  input  wire logic       wdt_timeout,
  input  wire logic       slew_busy,
  input  wire analog_in_t analog,
  input  wire logic [15:0] trim_rom_data,
  input  wire logic [7:0] crc_reference,
  // outputs
  output logic [3:0]      trim_rom_addr,
  output action_t         actions,
  output logic            fault_o,
  output logic            fault_oe_n
);

  state_t s;
  state_t n;
  state_t keep;
  logic              take;
  logic              osc_edge;
  logic              do_reset;
  logic              start_refresh;
  logic              crc_evt;
  logic              inv_evt;
  logic [7:0]        crc_next;
  logic [15:0]       key;
  logic [31:0]       wd;
  logic [31:0]       rd_word;
  logic [DF_W-1:0]   dw1;
  logic [AF_W-1:0]   aw1;
  logic [DF_W-1:0]   dset;
  logic [AF_W-1:0]   acur;

  // next-state logic
  always_comb begin
    n = s;
    keep = s;
    n.wdt_restart = 1'b0;
    n.adc_start = 1'b0;
    n.dev_reset = 1'b0;
    do_reset = 1'b0;
    start_refresh = 1'b0;
    crc_evt = 1'b0;
    inv_evt = 1'b0;
    dw1 = '0;
    aw1 = '0;
    wd = bus_in.hwdata;
    key = wd[15:0];
    crc_next = crc8_word(s.crc, trim_rom_data);

    // oscillator and reset pin synchronisers, change counted when stages agree
    n.osc_s1 = osc_clk;
    n.osc_s2 = s.osc_s1;
    n.osc_s3 = s.osc_s2;
    osc_edge = (s.osc_s2 == s.osc_s3) && s.osc_s3 && !s.osc_lvl;
    if (s.osc_s2 == s.osc_s3) n.osc_lvl = s.osc_s3;
    n.rst_s1 = reset_pin_n;
    n.rst_s2 = s.rst_s1;
    n.rst_s3 = s.rst_s2;
    if (s.rst_s2 == s.rst_s3) n.rst_lvl = s.rst_s3;

    // stop detector: no rising edge for the stop time
    if (osc_edge) begin
      n.osc_cnt = '0;
    end else if (!s.osc_stopped) begin
      n.osc_cnt = s.osc_cnt + 8'h01;
    end
    n.osc_stopped = !osc_edge && (s.osc_stopped || s.osc_cnt == 8'(OSC_STOP_CYCLES - 1));

    // tick divider and wrapping counter, held while disabled
    if (osc_edge && s.tick_en) begin  // [R11] [R22]
      if (s.div == 14'(OSC_DIV - 1)) begin  // [R10]
        n.div = '0;
        n.ticks = s.ticks + 16'h0001;
      end else begin
        n.div = s.div + 14'h0001;
      end
    end

    // read data phase: one wait state, then data
    if (s.rd_pend) begin
      n.hrdata = rd_word;
      n.hready = 1'b1;
      n.rd_pend = 1'b0;
    end
    n.wr_pend = 1'b0;
    take = bus_in.hsel && bus_in.htrans[1] && bus_in.hready;
    if (take) begin
      n.addr = (bus_in.haddr[31:ADDR_W] == '0) ? bus_in.haddr[ADDR_W-1:0] : OFF_NONE;
      if (bus_in.hwrite) begin
        n.wr_pend = 1'b1;
      end else begin
        n.rd_pend = 1'b1;
        n.hready = 1'b0;
      end
    end

    // write data phase
    if (s.wr_pend) begin
      if (s.wdt_any) n.wdt_restart = 1'b1;  // [R20]
      if (s.rf == RF_FETCH && s.addr != OFF_RBSEL && s.addr != OFF_NOP) begin
        inv_evt = 1'b1;  // [R8]
      end else begin
        unique case (s.addr)
          OFF_KEY: begin
            n.key_pend = 1'b0;  // [R21]
            if (key == KEY_RESET_A) begin
              n.key_pend = 1'b1;  // [R2]
            end else if (key == KEY_RESET_B && s.key_pend) begin
              do_reset = 1'b1;  // [R2] [R3]
            end else if (key == KEY_REFRESH) begin
              start_refresh = 1'b1;  // [R1] [R5]
            end else if (key == KEY_ADC) begin
              n.adc_start = 1'b1;  // [R1]
            end else if (key == KEY_WDT) begin
              n.wdt_restart = 1'b1;  // [R1] [R20]
            end
          end
          OFF_CONV: begin
            if (wd[3:0] != s.range) start_refresh = 1'b1;  // [R5]
            n.range = wd[3:0];
            n.int_en = wd[CONV_INT_EN];
          end
          OFF_DCFG: begin
            n.crc_en = wd[DC_CRC_EN];  // [R7]
            n.tick_en = wd[DC_TICK_EN];  // [R11]
            n.wdt_any = wd[DC_WDT_ANY];
            n.wdt_rst_en = wd[DC_WDT_RST];
          end
          OFF_GSA: begin
            n.sig_en = wd[GA_SIG_EN];
            n.trip_sel = wd[GA_TRIP+1:GA_TRIP];
          end
          OFF_GSB: n.cmp_en = wd[GB_CMP_EN];  // [R17]
          OFF_DRES: dw1 = wd[DF_W-1:0];
          OFF_ARES: aw1 = wd[AF_W-1:0];
          OFF_RBSEL: n.rb_sel = wd[4:0];
          default: ;
        endcase
      end
    end

    // calibration fetch, one word a cycle, crc checked at the last word
    if (s.rf == RF_FETCH) begin
      n.crc = crc_next;
      if (s.rom_addr == TRIM_LAST) begin
        n.rf = RF_IDLE;
        n.crc_bad = s.crc_en && (crc_next != crc_reference);  // [R6] [R7]
        crc_evt = n.crc_bad;  // [R6]
      end else begin
        n.rom_addr = s.rom_addr + 4'h1;
      end
    end
    if (start_refresh) begin
      n.rf = RF_FETCH;
      n.rom_addr = '0;
      n.crc = CRC_INIT;
    end

    // sticky flags: events and live faults win over a write-1 reload
    dset = '0;
    dset[DF_CRC] = s.crc_bad | crc_evt;
    dset[DF_INVALID] = inv_evt;
    dset[DF_OSC] = s.osc_stopped;
    n.df = dset | (s.df & ~dw1);  // [R13]
    n.df[DF_TRIM] = s.df[DF_TRIM] && !(s.rf == RF_FETCH && n.rf == RF_IDLE);  // [R14]
    n.df[DF_SLEW] = slew_busy;  // [R14]
    acur = '0;
    acur[AF_TEMP] = analog.temp_trip[s.trip_sel];  // [R16]
    if (s.cmp_en) acur[AF_AVCC:AF_REFERENCE_INPUT_NODE] = analog.supply_bad;  // [R17] [R19]
    n.af = acur | (s.af & ~aw1);  // [R13]

    // device reset from pin, key pair or watchdog, bus and samplers survive
    if (!s.rst_lvl || (wdt_timeout && s.wdt_rst_en)) do_reset = 1'b1;  // [R3]
    if (do_reset) begin
      keep = n;
      n = STATE_RESET;  // [R4]
      n.hready = keep.hready;
      n.hrdata = keep.hrdata;
      n.rd_pend = keep.rd_pend;
      n.wr_pend = keep.wr_pend;
      n.addr = keep.addr;
      {n.osc_s1, n.osc_s2, n.osc_s3, n.osc_lvl} =
        {keep.osc_s1, keep.osc_s2, keep.osc_s3, keep.osc_lvl};
      n.osc_cnt = keep.osc_cnt;
      n.osc_stopped = keep.osc_stopped;
      {n.rst_s1, n.rst_s2, n.rst_s3, n.rst_lvl} =
        {keep.rst_s1, keep.rst_s2, keep.rst_s3, keep.rst_lvl};
      n.dev_reset = 1'b1;
    end
    n.fault_oe_n = !n.af[AF_TEMP];  // [R16]
  end

  // register read multiplexer
  always_comb begin
    rd_word = '0;
    unique case (s.addr)
      OFF_CONV: rd_word = 32'({s.int_en, s.range});
      OFF_DCFG: rd_word = 32'({s.wdt_rst_en, s.wdt_any, s.tick_en, s.crc_en});
      OFF_GSA: rd_word = 32'({s.trip_sel, s.sig_en});
      OFF_GSB: rd_word = 32'(s.cmp_en);
      OFF_DRES: rd_word = 32'(s.df);
      OFF_ARES: rd_word = 32'(s.af);
      OFF_STATUS: begin
        rd_word[ST_DIG] = |(s.df & DF_SUM_MASK);  // [R15]
        rd_word[ST_ANA] = |s.af;  // [R15]
      end
      OFF_TICKS: rd_word = 32'(s.ticks);  // [R10]
      OFF_RBSEL: rd_word = 32'(s.rb_sel);
      default: rd_word = '0;
    endcase
    if (s.osc_stopped && s.sig_en) rd_word = HALT_SIGNATURE;  // [R12]
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= STATE_RESET;
    end else begin
      s <= n;
    end
  end

  // outputs straight from state
  assign bus_out.hreadyout = s.hready;
  assign bus_out.hresp = s.hresp;
  assign bus_out.hrdata = s.hrdata;
  assign trim_rom_addr = s.rom_addr;
  assign actions.wdt_restart = s.wdt_restart;
  assign actions.adc_start = s.adc_start;
  assign actions.dev_reset = s.dev_reset;
  assign fault_o = s.hresp;
  assign fault_oe_n = s.fault_oe_n;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_reset_pair: assert property (  // [R2]
    s.wr_pend && s.addr == OFF_KEY && s.rf == RF_IDLE && s.key_pend
    && bus_in.hwdata[15:0] == KEY_RESET_B |=> s.dev_reset && s.df[DF_RESET])
    else $error("reset key pair did not reset");
  chk_key_cancel: assert property (  // [R21]
    s.wr_pend && s.addr == OFF_KEY && s.rf == RF_IDLE
    && bus_in.hwdata[15:0] != KEY_RESET_A |=> !s.key_pend)
    else $error("pending reset not cancelled");
  chk_range_refresh: assert property (  // [R5]
    s.wr_pend && s.addr == OFF_CONV && s.rf == RF_IDLE && s.rst_lvl
    && bus_in.hwdata[3:0] != s.range |=> s.rf == RF_FETCH ##16 s.rf == RF_IDLE)
    else $error("range change refresh wrong");
  chk_crc_flag: assert property (  // [R6]
    $fell(s.rf == RF_FETCH) && s.crc_bad && !s.dev_reset |-> s.df[DF_CRC])
    else $error("crc error not flagged");
  chk_invalid_access: assert property (  // [R8]
    s.wr_pend && s.rf == RF_FETCH && s.addr != OFF_RBSEL && s.addr != OFF_NOP && !do_reset
    |=> s.df[DF_INVALID] && !s.dev_reset)
    else $error("invalid access not flagged");
  chk_tick_step: assert property (  // [R10]
    !s.dev_reset && s.ticks != $past(s.ticks) |-> s.ticks == $past(s.ticks) + 16'h0001)
    else $error("counter stepped wrongly");
  chk_tick_hold: assert property (  // [R11]
    !s.tick_en ##1 !s.dev_reset |-> $stable(s.ticks))
    else $error("counter moved while disabled");
  chk_sticky_hold: assert property (  // [R13]
    s.df[DF_INVALID] && !(s.wr_pend && s.addr == OFF_DRES) && !do_reset
    |=> s.df[DF_INVALID])
    else $error("sticky flag lost");
  chk_signature: assert property (  // [R12]
    s.rd_pend && s.osc_stopped && s.sig_en |=> s.hready && s.hrdata == HALT_SIGNATURE)
    else $error("halt signature missing");
  chk_temp_fault: assert property (  // [R16]
    analog.temp_trip[s.trip_sel] && !do_reset |=> s.af[AF_TEMP] && !fault_oe_n)
    else $error("temperature trip not flagged");
  chk_summary_bit: assert property (  // [R15]
    s.rd_pend && s.addr == OFF_STATUS && !(s.osc_stopped && s.sig_en)
    |=> s.hrdata[ST_DIG] == |($past(s.df) & DF_SUM_MASK))
    else $error("digital summary wrong");
endmodule : key_diag_monitor

// ### hdl/key_diag_pkg.sv
/*
  constants, carriers and state layout of the key-code and diagnostic monitor.
  assumes a 100 MHz bus clock and a sampled oscillator input.
*/
package key_diag_pkg;
  localparam int CLK_MHZ = 100;
  // register byte offsets
  localparam logic [7:0] OFF_KEY    = 8'h00;
  localparam logic [7:0] OFF_CONV   = 8'h04;
  localparam logic [7:0] OFF_DCFG   = 8'h08;
  localparam logic [7:0] OFF_GSA    = 8'h0C;
  localparam logic [7:0] OFF_GSB    = 8'h10;
  localparam logic [7:0] OFF_DRES   = 8'h14;
  localparam logic [7:0] OFF_ARES   = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_TICKS  = 8'h20;
  localparam logic [7:0] OFF_RBSEL  = 8'h24;
  localparam logic [7:0] OFF_NOP    = 8'h28;
  localparam logic [7:0] OFF_NONE   = 8'hFC;
  localparam int         ADDR_W     = 8;
  // key codes (refresh, adc and watchdog values are arbitrary)
  localparam logic [15:0] KEY_REFRESH = 16'hFCBA;
  localparam logic [15:0] KEY_ADC     = 16'h1ADC;
  localparam logic [15:0] KEY_WDT     = 16'h0D06;
  localparam logic [15:0] KEY_RESET_A = 16'h15FA;
  localparam logic [15:0] KEY_RESET_B = 16'hAF51;
  // field positions
  localparam int CONV_INT_EN = 4;
  localparam int DC_CRC_EN = 0, DC_TICK_EN = 1, DC_WDT_ANY = 2, DC_WDT_RST = 3;
  localparam int GA_SIG_EN = 0, GA_TRIP = 1;
  localparam int GB_CMP_EN = 0;
  localparam int DF_RESET = 0, DF_CRC = 1, DF_INVALID = 2, DF_TRIM = 3, DF_SLEW = 4;
  localparam int DF_OSC = 5, DF_W = 6;
  localparam int AF_TEMP = 0, AF_REFERENCE_INPUT_NODE = 1, AF_REFERENCE_OUTPUT_NODE = 2, AF_REGUL = 3, AF_AVCC = 4;
  localparam int AF_W = 5;
  localparam int ST_DIG = 0, ST_ANA = 1;
  localparam logic [DF_W-1:0] DF_RESET_VAL = 6'h09;
  localparam logic [DF_W-1:0] DF_SUM_MASK  = 6'h2F;
  localparam logic [31:0]     HALT_SIGNATURE = 32'h0007DEAD;
  // calibration fetch and crc
  localparam logic [3:0] TRIM_LAST = 4'hF;
  localparam logic [7:0] CRC_INIT  = 8'h00;
  localparam logic [7:0] CRC_POLY  = 8'h07;
  // oscillator supervision
  localparam int OSC_STOP_NS     = 1000;
  localparam int OSC_STOP_CYCLES = (OSC_STOP_NS * CLK_MHZ + 999) / 1000;
  localparam int OSC_DIV_DEFAULT = 10000;

  typedef enum logic {RF_IDLE, RF_FETCH} refresh_state_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_in_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ahb_out_t;

  typedef struct packed {
    logic [3:0] temp_trip;   // one comparator per trip point
    logic [3:0] supply_bad;  // reference_input_node, reference_output_node, regulator, analog supply
  } analog_in_t;

  typedef struct packed {
    logic wdt_restart;
    logic adc_start;
    logic dev_reset;
  } action_t;

  typedef struct packed {
    logic hready; logic hresp; logic [31:0] hrdata; logic rd_pend; logic wr_pend;
    logic [7:0] addr; logic [3:0] range; logic int_en; logic crc_en; logic tick_en;
    logic wdt_any; logic wdt_rst_en; logic sig_en; logic [1:0] trip_sel; logic cmp_en;
    logic [4:0] rb_sel; logic [DF_W-1:0] df; logic [AF_W-1:0] af; logic key_pend;
    refresh_state_t rf; logic [3:0] rom_addr; logic [7:0] crc; logic crc_bad;
    logic osc_s1; logic osc_s2; logic osc_s3; logic osc_lvl; logic [7:0] osc_cnt;
    logic osc_stopped; logic [13:0] div; logic [15:0] ticks;
    logic rst_s1; logic rst_s2; logic rst_s3; logic rst_lvl;
    logic wdt_restart; logic adc_start; logic dev_reset; logic fault_oe_n;
  } state_t;

  localparam state_t STATE_RESET = '{hready: 1'b1, crc_en: 1'b1, tick_en: 1'b1,
    sig_en: 1'b1, df: DF_RESET_VAL, rf: RF_IDLE, rst_s1: 1'b1, rst_s2: 1'b1,
    rst_s3: 1'b1, rst_lvl: 1'b1, fault_oe_n: 1'b1, default: '0};

  // crc-8 over one 16-bit word, msb first
  function automatic logic [7:0] crc8_word(input logic [7:0] c, input logic [15:0] w);
    logic [7:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[7] ^ w[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc8_word
endpackage : key_diag_pkg
